// [core/port_mux_defs.vh]
`ifndef PORT_MUX_DEFS_VH
`define PORT_MUX_DEFS_VH
// ----------------------------------------
// register map, byte addresses
// ----------------------------------------
`define ADDR_W 16
`define ADDR_PORT4_DATA 16'hFFC8
`define ADDR_PORT4_DIR 16'hFFCA
`define ADDR_PORT4_OD 16'hF1CA
`define ADDR_P3_DATA 16'hFFC4
`define ADDR_P3_DIR 16'hFFC6
`define ADDR_RST_CFG 16'hF100
`define ADDR_PERIPH_CFG 16'hF024
`define ADDR_SYS_CFG 16'hF026
// ----------------------------------------
// reset values and fields
// ----------------------------------------
`define PORT4_RESET 8'h00
`define P3_RESET 16'h0000
`define OD_MASK 8'hC0
`define SEG_NONE 2'h1
`define SEG_TWO 2'h3
`define SEG_FOUR 2'h0
`define SEG_EIGHT 2'h2
`define SEG_MASK_NONE 8'h00
`define SEG_MASK_TWO 8'h03
`define SEG_MASK_FOUR 8'h0F
`define SEG_MASK_EIGHT 8'hFF
`define CAN_A_EN_BIT 0
`define CAN_B_EN_BIT 1
`define CLK_OUT_EN_BIT 0
`define BYTE_DIS_FREE_BIT 1
`define WR_CFG_FREE_BIT 2
`define CLK_OUT_PIN 15
`define STROBE_PIN 12
`define NOPIN_BIT 14
`define CAN_B_RX_PIN 4
`define CAN_A_RX_PIN 5
`define CAN_A_TX_PIN 6
`define CAN_B_TX_PIN 7
`endif

// [core/port3_port4_pin_function_logic.v]
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "port_mux_defs.vh"
module port3_port4_pin_function_logic #(
  parameter P3_W = 16,
  parameter PORT4_W = 8
) (
  input wire sys_clk,
  input wire resetn,
  input wire [`ADDR_W-1:0] addr,
  input wire [15:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [15:0] rdata,
  input wire [1:0] seg_select_strap,
  input wire byte_high_disable_strap,
  input wire write_config_strap,
  input wire bus_hold,
  input wire [7:0] segment_address,
  input wire system_clock_out,
  input wire byte_high_write_high_strobe,
  input wire timer6_toggle_out,
  input wire timer3_toggle_out,
  input wire uart_tx_out,
  input wire sync_rx_line_out,
  input wire sync_tx_line_out,
  input wire uart_rx_out,
  input wire sync_sclk_out,
  input wire can_a_transmit,
  input wire can_b_transmit,
  output wire timer0_count_in,
  output wire timer_unit2_capture_in,
  output wire timer3_updown_in,
  output wire timer4_count_in,
  output wire timer3_count_in,
  output wire timer2_count_in,
  output wire sync_master_rx_slave_tx,
  output wire sync_master_tx_slave_rx,
  output wire uart_rx_in,
  output wire sync_sclk_in,
  output wire can_a_receive,
  output wire can_b_receive,
  input wire [P3_W-1:0] p3_pin_in,
  output reg [P3_W-1:0] p3_pin_out,
  output reg [P3_W-1:0] p3_pin_oe,
  input wire [PORT4_W-1:0] port4_pin_in,
  output reg [PORT4_W-1:0] port4_pin_out,
  output reg [PORT4_W-1:0] port4_pin_oe
);

  // ----------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------
  reg rst_meta_reg;
  reg rst_sync_reg;
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire rstn = rst_sync_reg;

  reg [P3_W-1:0] p3_meta_reg;
  reg [P3_W-1:0] p3_in_reg;
  reg [PORT4_W-1:0] port4_meta_reg;
  reg [PORT4_W-1:0] port4_in_reg;
  reg [3:0] strap_meta_reg;
  reg [3:0] strap_sync_reg;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      p3_meta_reg <= {P3_W{1'b0}};
      p3_in_reg <= {P3_W{1'b0}};
      port4_meta_reg <= {PORT4_W{1'b0}};
      port4_in_reg <= {PORT4_W{1'b0}};
    end else begin
      p3_meta_reg <= p3_pin_in;
      p3_in_reg <= p3_meta_reg;
      port4_meta_reg <= port4_pin_in;
      port4_in_reg <= port4_meta_reg;
    end
  end
  // straps sampled every cycle, captured into config while reset is held
  always @(posedge sys_clk) begin
    strap_meta_reg <= {write_config_strap, byte_high_disable_strap, seg_select_strap};
    strap_sync_reg <= strap_meta_reg;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [P3_W-1:0] p3_data_reg;
  reg [P3_W-1:0] p3_dir_reg;
  reg [PORT4_W-1:0] port4_data_reg;
  reg [PORT4_W-1:0] port4_dir_reg;
  reg [PORT4_W-1:0] port4_od_reg;
  reg [1:0] seg_sel_reg;
  reg byte_dis_reg;
  reg wr_cfg_reg;
  reg [1:0] periph_cfg_reg;
  reg [2:0] sys_cfg_reg;

  // held config follows straps until the reset copy is released
  always @(posedge sys_clk) begin
    if (!rstn) begin
      seg_sel_reg <= strap_sync_reg[1:0];
      byte_dis_reg <= strap_sync_reg[2];
      wr_cfg_reg <= strap_sync_reg[3];
    end
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      p3_data_reg <= `P3_RESET;
      p3_dir_reg <= `P3_RESET;
      port4_data_reg <= `PORT4_RESET;
      port4_dir_reg <= `PORT4_RESET;
      port4_od_reg <= `PORT4_RESET;
      periph_cfg_reg <= 2'h0;
      sys_cfg_reg <= 3'h0;
    end else if (wr_stb) begin
      case (addr)
        `ADDR_P3_DATA: p3_data_reg <= wdata[P3_W-1:0];
        `ADDR_P3_DIR: p3_dir_reg <= wdata[P3_W-1:0];
        `ADDR_PORT4_DATA: port4_data_reg <= wdata[PORT4_W-1:0];
        `ADDR_PORT4_DIR: port4_dir_reg <= wdata[PORT4_W-1:0];
        `ADDR_PORT4_OD: port4_od_reg <= wdata[7:0] & `OD_MASK;
        `ADDR_PERIPH_CFG: periph_cfg_reg <= wdata[1:0];
        `ADDR_SYS_CFG: sys_cfg_reg <= wdata[2:0];
        default: p3_data_reg <= p3_data_reg;
      endcase
    end
  end

  // ----------------------------------------
  // read port, data in the cycle after strobe
  // ----------------------------------------
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 16'h0000;
    end else if (rd_stb) begin
      case (addr)
        `ADDR_P3_DATA: rdata <= p3_data_reg;
        `ADDR_P3_DIR: rdata <= p3_dir_reg;
        `ADDR_PORT4_DATA: rdata <= {8'h00, port4_data_reg};
        `ADDR_PORT4_DIR: rdata <= {8'h00, port4_dir_reg};
        `ADDR_PORT4_OD: rdata <= {8'h00, port4_od_reg};
        `ADDR_RST_CFG: rdata <= {12'h000, wr_cfg_reg, byte_dis_reg, seg_sel_reg};
        `ADDR_PERIPH_CFG: rdata <= {14'h0000, periph_cfg_reg};
        `ADDR_SYS_CFG: rdata <= {13'h0000, sys_cfg_reg};
        default: rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

  // ----------------------------------------
  // first port
  // ----------------------------------------
  wire system_clock_out_en = sys_cfg_reg[`CLK_OUT_EN_BIT];
  // strobe active when strap says so, software has not freed it and bus_hold is low
  wire byte_dis_eff = byte_dis_reg | sys_cfg_reg[`BYTE_DIS_FREE_BIT];
  wire wr_cfg_eff = wr_cfg_reg & ~sys_cfg_reg[`WR_CFG_FREE_BIT];
  wire strobe_en = (~byte_dis_eff | wr_cfg_eff) & ~bus_hold;

  // idle peripheral outputs must be driven high by their owners
  // clock and strobe pins are overridden below, so their gate rests high
  // and the latch alone rules them in port mode
  reg [P3_W-1:0] alt_out;
  always @* begin
    alt_out = {P3_W{1'b1}};
    alt_out[1] = timer6_toggle_out;
    alt_out[3] = timer3_toggle_out;
    alt_out[8] = sync_rx_line_out;
    alt_out[9] = sync_tx_line_out;
    alt_out[10] = uart_tx_out;
    alt_out[11] = uart_rx_out;
    alt_out[13] = sync_sclk_out;
  end

  always @* begin
    p3_pin_out = alt_out & p3_data_reg;
    p3_pin_oe = p3_dir_reg;
    p3_pin_out[`NOPIN_BIT] = 1'b0;
    p3_pin_oe[`NOPIN_BIT] = 1'b0;
    if (system_clock_out_en) begin
      p3_pin_out[`CLK_OUT_PIN] = system_clock_out;
      p3_pin_oe[`CLK_OUT_PIN] = 1'b1;
    end
    if (strobe_en) begin
      p3_pin_out[`STROBE_PIN] = byte_high_write_high_strobe;
      p3_pin_oe[`STROBE_PIN] = 1'b1;
    end
  end

  // input latch copies, not output latch
  assign timer0_count_in = p3_in_reg[0];
  assign timer_unit2_capture_in = p3_in_reg[2];
  assign timer3_updown_in = p3_in_reg[4];
  assign timer4_count_in = p3_in_reg[5];
  assign timer3_count_in = p3_in_reg[6];
  assign timer2_count_in = p3_in_reg[7];
  assign sync_master_rx_slave_tx = p3_in_reg[8];
  assign sync_master_tx_slave_rx = p3_in_reg[9];
  assign uart_rx_in = p3_in_reg[11];
  assign sync_sclk_in = p3_in_reg[13];

  // ----------------------------------------
  // second port
  // ----------------------------------------
  reg [PORT4_W-1:0] seg_mask;
  always @* begin
    case (seg_sel_reg)
      `SEG_NONE: seg_mask = `SEG_MASK_NONE;
      `SEG_TWO: seg_mask = `SEG_MASK_TWO;
      `SEG_FOUR: seg_mask = `SEG_MASK_FOUR;
      `SEG_EIGHT: seg_mask = `SEG_MASK_EIGHT;
      default: seg_mask = `SEG_MASK_NONE;
    endcase
  end

  reg [PORT4_W-1:0] port4_val;
  integer i;
  always @* begin
    port4_val = port4_data_reg;
    if (periph_cfg_reg[`CAN_A_EN_BIT]) begin
      port4_val[`CAN_A_TX_PIN] = can_a_transmit;
    end
    if (periph_cfg_reg[`CAN_B_EN_BIT]) begin
      port4_val[`CAN_B_TX_PIN] = can_b_transmit;
    end
    for (i = 0; i < PORT4_W; i = i + 1) begin
      if (seg_mask[i]) begin
        port4_pin_out[i] = segment_address[i];
        port4_pin_oe[i] = 1'b1;
      end else if (port4_od_reg[i]) begin
        // open drain only pulls low
        port4_pin_out[i] = 1'b0;
        port4_pin_oe[i] = port4_dir_reg[i] & ~port4_val[i];
      end else begin
        port4_pin_out[i] = port4_val[i];
        port4_pin_oe[i] = port4_dir_reg[i];
      end
    end
  end

  assign can_a_receive = port4_in_reg[`CAN_A_RX_PIN];
  assign can_b_receive = port4_in_reg[`CAN_B_RX_PIN];

endmodule

// [test/pin_mux_chk.sv]
`timescale 1ns/1ps
module pin_mux_chk (
  input wire sys_clk,
  input wire resetn,
  input wire [15:0] addr,
  input wire rd_stb,
  input wire [15:0] rdata,
  input wire [1:0] seg_select_strap,
  input wire byte_high_disable_strap,
  input wire write_config_strap,
  input wire bus_hold,
  input wire [7:0] segment_address,
  input wire timer6_toggle_out,
  input wire timer3_toggle_out,
  input wire uart_tx_out,
  input wire timer0_count_in,
  input wire can_a_receive,
  input wire [15:0] p3_pin_in,
  input wire [15:0] p3_pin_out,
  input wire [15:0] p3_pin_oe,
  input wire [7:0] port4_pin_in,
  input wire [7:0] port4_pin_out,
  input wire [7:0] port4_pin_oe
);
  // ----
  // pin checks
  // ----
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // straps only move under reset, so decode them live
  wire [7:0] m = seg_select_strap == 2'h0 ? 8'h0F :
    seg_select_strap == 2'h3 ? 8'h03 : {8{seg_select_strap[1]}};
  wire [15:0] alt = {5'h00, uart_tx_out, 6'h00, timer3_toggle_out, 1'b0,
    timer6_toggle_out, 1'b0};
  wire stb_on = !byte_high_disable_strap || write_config_strap;
  property p_seg; (port4_pin_oe & m) == m; endproperty
  property p_seg_out; ((port4_pin_out ^ segment_address) & m) == 8'h00; endproperty
  property p_alt_in; $past(resetn, 5) |-> timer0_count_in == $past(p3_pin_in[0], 2);
  endproperty
  property p_can_rx; $past(resetn, 5) |-> can_a_receive == $past(port4_pin_in[5], 2);
  endproperty
  property p_alt_out; (p3_pin_out & p3_pin_oe & ~alt & 16'h040A) == 16'h0000; endproperty
  property p_od_rd; rd_stb && addr == 16'hF1CA |=> (rdata & 16'hFF3F) == 16'h0000;
  endproperty
  property p_cfg_rd; rd_stb && addr == 16'hF100 |=> rdata[1:0] == seg_select_strap;
  endproperty
  property p_strobe; stb_on && !bus_hold && !$past(bus_hold) |-> p3_pin_oe[12];
  endproperty
  a_seg: assert property (p_seg) else $error("segment enables wrong");
  a_seg_out: assert property (p_seg_out) else $error("segment value wrong");
  a_alt_in: assert property (p_alt_in) else $error("alternate input stale");
  a_can_rx: assert property (p_can_rx) else $error("receive line stale");
  a_alt_out: assert property (p_alt_out) else $error("alternate output not gated");
  a_od_rd: assert property (p_od_rd) else $error("open drain readback wrong");
  a_cfg_rd: assert property (p_cfg_rd) else $error("segment field wrong");
  a_strobe: assert property (p_strobe) else $error("strobe driver off");
endmodule
bind port3_port4_pin_function_logic pin_mux_chk pin_mux_chk_inst (.sys_clk, .resetn,
  .addr, .rd_stb, .rdata, .seg_select_strap, .byte_high_disable_strap,
  .write_config_strap, .bus_hold, .segment_address, .timer6_toggle_out,
  .timer3_toggle_out, .uart_tx_out, .timer0_count_in, .can_a_receive, .p3_pin_in,
  .p3_pin_out, .p3_pin_oe, .port4_pin_in, .port4_pin_out, .port4_pin_oe);

// [test/pin_world.sv]
`timescale 1ns/1ps
module pin_world (
  input wire [15:0] o3,
  input wire [15:0] e3,
  input wire [7:0] o4,
  input wire [7:0] e4,
  input wire [23:0] ext,
  output wire [15:0] p3,
  output wire [7:0] p4
);
  // ----
  // board level
  // ----
  // released lines follow outside traffic, never the last driven value
  assign p3 = (o3 & e3) | (ext[15:0] & ~e3);
  assign p4 = (o4 & e4) | (ext[23:16] & ~e4);
endmodule

// [test/port3_port4_pin_function_logic_tb.sv]
`timescale 1ns/1ps
module port3_port4_pin_function_logic_tb;
  // ----
  // stimulus and checking
  // ----
  reg sys_clk = 0, resetn = 0, wr_stb = 0, rd_stb = 0, bus_hold = 0, rd_q = 0;
  reg bd = 0, wc = 0, stb = 0;
  reg [1:0] seg = 0, tx = 0;
  reg [6:0] alt = 7'h7F;
  reg [7:0] sa = 0, d;
  reg [15:0] addr = 0, wdata = 0;
  reg [23:0] ext = 0;
  reg [31:0] rs = 32'h02E8;
  wire [15:0] rdata, p3o, p3e, p3i;
  wire [7:0] p4o, p4e, p4i;
  integer fails = 0, n_tests = 0, i;
  reg [15:0] q[$];
  port3_port4_pin_function_logic port3_port4_pin_function_logic_inst (
    .sys_clk, .resetn, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
    .seg_select_strap(seg), .byte_high_disable_strap(bd), .write_config_strap(wc),
    .bus_hold, .segment_address(sa), .system_clock_out(stb),
    .byte_high_write_high_strobe(stb), .uart_tx_out(alt[0]), .timer6_toggle_out(alt[1]),
    .timer3_toggle_out(alt[2]), .sync_rx_line_out(alt[3]), .sync_tx_line_out(alt[4]),
    .uart_rx_out(alt[5]), .sync_sclk_out(alt[6]), .can_a_transmit(tx[0]),
    .can_b_transmit(tx[1]), .timer0_count_in(), .timer_unit2_capture_in(),
    .timer3_updown_in(), .timer4_count_in(), .timer3_count_in(), .timer2_count_in(),
    .sync_master_rx_slave_tx(), .sync_master_tx_slave_rx(), .uart_rx_in(),
    .sync_sclk_in(), .can_a_receive(), .can_b_receive(), .p3_pin_in(p3i),
    .p3_pin_out(p3o), .p3_pin_oe(p3e), .port4_pin_in(p4i), .port4_pin_out(p4o),
    .port4_pin_oe(p4e));
  pin_world pin_world_inst (.o3(p3o), .e3(p3e), .o4(p4o), .e4(p4e), .ext, .p3(p3i),
    .p4(p4i));
  initial forever #50 sys_clk = ~sys_clk;
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  function [7:0] m(input [1:0] s);
    m = s == 2'h0 ? 8'h0F : s == 2'h3 ? 8'h03 : {8{s[1]}};
  endfunction
  task chk(input [15:0] g, e);
    begin
      n_tests++;
      if (g !== e) begin
        fails++;
        $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  // a read carries its expected word instead of write data
  task acc(input w, input [15:0] a, dat);
    begin
      {wr_stb, rd_stb} <= {w, !w};
      addr <= a;
      wdata <= dat;
      if (!w) q.push_back(dat);
      @(posedge sys_clk);
    end
  endtask
  task idle;
    begin
      {wr_stb, rd_stb} <= 2'b00;
      rs = xs(rs);
      ext <= rs[23:0];
      stb <= rs[24];
      repeat (2) @(posedge sys_clk);
    end
  endtask
  task rst(input [3:0] c);
    begin
      resetn <= 0;
      {wc, bd, seg} <= c;
      repeat (16) @(posedge sys_clk);
      resetn <= 1;
      repeat (3) @(posedge sys_clk);
    end
  endtask
  task report_and_stop;
    begin
      if (fails == 0 && n_tests > 0) begin
        $display("All checks passed");
      end else begin
        $display("Checks failed");
      end
      $finish;
    end
  endtask
  always @(posedge sys_clk) begin
    if (rd_q) chk(rdata, q.pop_front());
    rd_q <= rd_stb;
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    fails++;
    report_and_stop;
  end
  initial begin
    for (i = 0; i < 4; i++) begin
      rst({i[1:0], i[1:0]});
      sa <= rs[31:24];
      acc(0, 16'hF100, {12'h000, i[1:0], i[1:0]});
      idle;
      chk(p4e, m(i[1:0]));
      chk(p4o & m(i[1:0]), sa & m(i[1:0]));
      chk(p3e[12], i != 1);
      bus_hold <= 1;
      idle;
      chk(p3e[12], 0);
      bus_hold <= 0;
    end
    // no segment lines, strobe freed for general use
    rst(4'h5);
    d = rs[7:0];
    acc(1, 16'hFFC8, {rs[15:8], d});
    acc(1, 16'hFFCA, 16'hFFFF);
    acc(1, 16'hF1CA, 16'hFFFF);
    acc(0, 16'hFFC8, {8'h00, d});
    acc(0, 16'hF1CA, 16'h00C0);
    acc(0, 16'hFFCA, 16'h00FF);
    acc(0, 16'h1234, 16'h0000);
    idle;
    chk(p4e, {~d[7:6], 6'h3F});
    chk(p4o, {2'b00, d[5:0]});
    acc(1, 16'hF1CA, 16'h0000);
    acc(1, 16'hF024, 16'h0003);
    for (i = 0; i < 4; i++) begin
      tx <= i[1:0];
      idle;
      chk(p4o[7:6], i[1:0]);
    end
    acc(1, 16'hFFC6, 16'h140A);
    acc(1, 16'hFFC4, 16'h1402);
    acc(1, 16'hF026, 16'h0001);
    for (i = 0; i < 2; i++) begin
      alt[1] <= i[0];
      idle;
      chk(p3o & 16'h140A, 16'h1400 | {14'h0000, i[0], 1'b0});
      chk(p3e & 16'h940A, 16'h940A);
    end
    bus_hold <= 1;
    idle;
    chk(p3e[12], 1);
    report_and_stop;
  end
endmodule
